// ### core/fwp_pkg.sv
// Constants for the flash write-protect and status logic.
// Assumes a 10 MHz system clock and an SPI link clock of its own.
`default_nettype none

package fwp_pkg;

  // System clock period in ns
  localparam int SYS_CLK_PERIOD_NS = 100;
  // Power-up write lockout delay in us (plain default)
  localparam int POWER_UP_WRITE_DELAY_US = 10;
  localparam int POWER_UP_WRITE_DELAY_CYC_CALC =
    (POWER_UP_WRITE_DELAY_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int POWER_UP_WRITE_DELAY_CYC =
    (POWER_UP_WRITE_DELAY_CYC_CALC < 1) ? 1 : POWER_UP_WRITE_DELAY_CYC_CALC;
  localparam int PUW_CNT_W = 24;

  // Command opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE_32 = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE_64 = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_RELEASE_PD = 8'hAB;

  // Status register bit positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_BP_LOW_BIT = 2;
  localparam int ST_BP_HIGH_BIT = 3;
  localparam int ST_TB_BIT = 5;
  localparam int ST_LOCK_BIT = 7;

  // Factory defaults of the non-volatile bits
  localparam logic NV_DEFAULT = 1'b0;

  // Byte counts that frame a command
  localparam logic [2:0] BYTES_STATUS_WRITE = 3'h2;
  localparam logic [2:0] BYTES_ADDRESSED = 3'h4;
  localparam logic [2:0] BYTES_MAX = 3'h4;

  typedef enum logic [3:0] {
    FWP_LOCKOUT = 4'h1,
    FWP_READY = 4'h2,
    FWP_BUSY = 4'h4,
    FWP_POWER_DOWN = 4'h8
  } fwp_state_t;

endpackage : fwp_pkg

`default_nettype wire

// ### core/fwp_core.sv
// Write-protect, write-enable and status logic of a serial flash.
// Assumes an SPI host on spi_clk/cs_n/si/so and an array engine on sys_clk
// that starts on op_start and pulses op_done when the operation ends.
`default_nettype none

// Function
// - While reset is held, all operations are disabled and no command is recognised.
// - After reset release, write-type commands are rejected for the power-up write delay.
// - After power-up the write enable latch reads 0.
// - Program, erase and status write are refused unless the write enable latch is set.
// - Write disable and finished program, erase or status write clear the latch.
// - Write enable sets the write enable latch, read-only status bit 1.
// - Busy, status bit 0, is 1 while program, erase or status write runs.
// - While busy, every command except read status is ignored.
// - When the internal operation completes, busy clears and commands are accepted.
// - Block-protect bits sit at status bits 3 and 2, loaded by status write.
// - Block-protect bits default to 0, nothing protected.
// - Top/bottom bit 0 protects from the top, 1 from the bottom; default 0.
// - Reserved status bits 6 and 4 read as 0.
// - Register-lock bit sits at status bit 7, default 0.
// - With register-lock 0 the write-protect pin has no effect.
// - Register-lock 1 with write-protect low refuses status writes.
// - In power-down only release-from-power-down and read status are obeyed.
// - Program or erase touching a protected region is ignored.
// - Write, program or erase not ending on a byte boundary has no effect.
module fwp_core
  import fwp_pkg::*;
#(
  parameter int POWER_UP_DELAY_CYCLES = POWER_UP_WRITE_DELAY_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe_n,
  input wire logic write_protect_n,
  input wire logic op_done,
  output logic op_start,
  output logic [7:0] op_opcode,
  output logic op_upper_half,
  output logic [7:0] protection_status_register,
  output logic power_down
);

  // Protected-region decode, used for addressed and chip-wide commands
  function automatic logic region_protected(input logic bp_high, input logic bp_low,
                                            input logic tb, input logic upper,
                                            input logic whole_chip);
    logic hit;
    hit = 1'b0;
    if (bp_high) begin
      hit = 1'b1;
    end else if (bp_low) begin
      hit = whole_chip ? 1'b1 : (upper != tb);
    end
    return hit;
  endfunction : region_protected

  // ---------------- Link domain (spi_clk) ----------------
  logic frame_started;
  logic [2:0] bit_idx;
  logic [2:0] byte_cnt;
  logic [7:0] shift_in;
  logic [7:0] link_opcode;
  logic [7:0] link_byte1;
  logic [2:0] next_bit_idx;
  logic [2:0] next_byte_cnt;
  logic [7:0] next_shift_in;
  logic [7:0] next_link_opcode;
  logic [7:0] next_link_byte1;
  logic active_meta;
  logic active_link;
  logic [7:0] status_snap;
  logic sys_active;

  always_comb begin
    next_bit_idx = frame_started ? bit_idx + 3'h1 : 3'h1;
    next_shift_in = frame_started ? {shift_in[6:0], si} : {7'h00, si};
    next_byte_cnt = frame_started ? byte_cnt : 3'h0;
    next_link_opcode = link_opcode;
    next_link_byte1 = link_byte1;
    if (next_bit_idx == 3'h0) begin
      if (next_byte_cnt == 3'h0) begin
        next_link_opcode = next_shift_in;
      end
      if (next_byte_cnt == 3'h1) begin
        next_link_byte1 = next_shift_in;
      end
      if (next_byte_cnt != BYTES_MAX) begin
        next_byte_cnt = next_byte_cnt + 3'h1;
      end
    end
  end

  // Frame marker is cleared by the frame's own chip select
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      frame_started <= 1'b0;
    end else begin
      frame_started <= 1'b1;
    end
  end

  always_ff @(posedge spi_clk) begin
    bit_idx <= next_bit_idx;
    byte_cnt <= next_byte_cnt;
    shift_in <= next_shift_in;
    link_opcode <= next_link_opcode;
    link_byte1 <= next_link_byte1;
    active_meta <= sys_active;
    active_link <= active_meta;
  end

  // Status read: drive on falling edges once the opcode is in, MSB first
  always_ff @(negedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      so_oe_n <= 1'b1;
      so_out <= 1'b0;
    end else if (frame_started && active_link && byte_cnt != 3'h0 &&
                 link_opcode == OP_READ_STATUS) begin
      so_oe_n <= 1'b0;
      so_out <= status_snap[~bit_idx];
    end else begin
      so_oe_n <= 1'b1;
      so_out <= 1'b0;
    end
  end

  // ---------------- System domain (sys_clk) ----------------
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic wp_meta;
  logic wp_sync;
  fwp_state_t state;
  fwp_state_t next_state;
  logic [PUW_CNT_W-1:0] puw_cnt;
  logic [PUW_CNT_W-1:0] next_puw_cnt;
  logic write_enable_latch;
  logic next_write_enable_latch;
  logic block_protect_high;
  logic block_protect_low;
  logic top_bottom_select;
  logic register_lock_bit;
  logic next_block_protect_high;
  logic next_block_protect_low;
  logic next_top_bottom_select;
  logic next_register_lock_bit;
  logic next_op_start;
  logic [7:0] next_op_opcode;
  logic next_op_upper_half;
  logic [7:0] next_status_snap;
  logic [7:0] status_now;
  logic frame_end;
  logic aligned;
  logic upper;
  logic status_locked;

  assign frame_end = cs_sync & ~cs_prev;
  assign aligned = (bit_idx == 3'h0);
  assign upper = link_byte1[0];
  assign status_locked = register_lock_bit & ~wp_sync;
  assign sys_active = (state != FWP_LOCKOUT) || (puw_cnt != '0);

  always_comb begin
    status_now = 8'h00;
    status_now[ST_BUSY_BIT] = (state == FWP_BUSY);
    status_now[ST_WEL_BIT] = write_enable_latch;
    status_now[ST_BP_LOW_BIT] = block_protect_low;
    status_now[ST_BP_HIGH_BIT] = block_protect_high;
    status_now[ST_TB_BIT] = top_bottom_select;
    status_now[ST_LOCK_BIT] = register_lock_bit;
  end

  always_comb begin
    next_state = state;
    next_puw_cnt = puw_cnt;
    next_write_enable_latch = write_enable_latch;
    next_block_protect_high = block_protect_high;
    next_block_protect_low = block_protect_low;
    next_top_bottom_select = top_bottom_select;
    next_register_lock_bit = register_lock_bit;
    next_op_start = 1'b0;
    next_op_opcode = op_opcode;
    next_op_upper_half = op_upper_half;
    // Snapshot for the link is frozen while a frame is open
    next_status_snap = cs_sync ? status_now : status_snap;
    case (state)
      FWP_LOCKOUT: begin
        // The lockout counter runs; write enable is refused, power-down is still obeyed
        if (puw_cnt == PUW_CNT_W'(POWER_UP_DELAY_CYCLES - 1)) begin
          next_state = FWP_READY;
        end else begin
          next_puw_cnt = puw_cnt + 1'b1;
        end
        if (frame_end && link_opcode == OP_POWER_DOWN) begin
          next_state = FWP_POWER_DOWN;
        end
      end
      FWP_READY: begin
        if (frame_end) begin
          case (link_opcode)
            OP_WRITE_ENABLE: begin
              next_write_enable_latch = 1'b1;
            end
            OP_WRITE_DISABLE: begin
              next_write_enable_latch = 1'b0;
            end
            OP_WRITE_STATUS: begin
              // Refused writes leave latch and busy alone
              if (write_enable_latch && aligned && !status_locked &&
                  byte_cnt >= BYTES_STATUS_WRITE) begin
                next_block_protect_high = link_byte1[ST_BP_HIGH_BIT];
                next_block_protect_low = link_byte1[ST_BP_LOW_BIT];
                next_top_bottom_select = link_byte1[ST_TB_BIT];
                next_register_lock_bit = link_byte1[ST_LOCK_BIT];
                next_op_start = 1'b1;
                next_op_opcode = link_opcode;
                next_state = FWP_BUSY;
              end
            end
            OP_PAGE_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE_32, OP_BLOCK_ERASE_64: begin
              if (write_enable_latch && aligned && byte_cnt >= BYTES_ADDRESSED &&
                  !region_protected(block_protect_high, block_protect_low,
                                    top_bottom_select, upper, 1'b0)) begin
                next_op_start = 1'b1;
                next_op_opcode = link_opcode;
                next_op_upper_half = upper;
                next_state = FWP_BUSY;
              end
            end
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
              if (write_enable_latch && aligned &&
                  !region_protected(block_protect_high, block_protect_low,
                                    top_bottom_select, 1'b0, 1'b1)) begin
                next_op_start = 1'b1;
                next_op_opcode = link_opcode;
                next_op_upper_half = 1'b0;
                next_state = FWP_BUSY;
              end
            end
            OP_POWER_DOWN: begin
              next_state = FWP_POWER_DOWN;
            end
            default: begin
            end
          endcase
        end
      end
      FWP_BUSY: begin
        // Frames other than status polls are dropped here
        if (op_done) begin
          next_write_enable_latch = 1'b0;
          next_state = FWP_READY;
        end
      end
      FWP_POWER_DOWN: begin
        if (frame_end && link_opcode == OP_RELEASE_PD) begin
          next_state = (puw_cnt == PUW_CNT_W'(POWER_UP_DELAY_CYCLES - 1)) ?
                       FWP_READY : FWP_LOCKOUT;
        end
        if (puw_cnt != PUW_CNT_W'(POWER_UP_DELAY_CYCLES - 1)) begin
          next_puw_cnt = puw_cnt + 1'b1;
        end
      end
      default: begin
        next_state = FWP_LOCKOUT;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    cs_meta <= cs_n;
    cs_sync <= cs_meta;
    wp_meta <= write_protect_n;
    wp_sync <= wp_meta;
    if (!rst_n) begin
      // Reset holds everything idle and forgets any frame
      cs_prev <= 1'b1;
      state <= FWP_LOCKOUT;
      puw_cnt <= '0;
      write_enable_latch <= 1'b0;
      block_protect_high <= NV_DEFAULT;
      block_protect_low <= NV_DEFAULT;
      top_bottom_select <= NV_DEFAULT;
      register_lock_bit <= NV_DEFAULT;
      op_start <= 1'b0;
      op_opcode <= 8'h00;
      op_upper_half <= 1'b0;
      status_snap <= 8'h00;
      protection_status_register <= 8'h00;
      power_down <= 1'b0;
    end else begin
      cs_prev <= cs_sync;
      state <= next_state;
      puw_cnt <= next_puw_cnt;
      write_enable_latch <= next_write_enable_latch;
      block_protect_high <= next_block_protect_high;
      block_protect_low <= next_block_protect_low;
      top_bottom_select <= next_top_bottom_select;
      register_lock_bit <= next_register_lock_bit;
      op_start <= next_op_start;
      op_opcode <= next_op_opcode;
      op_upper_half <= next_op_upper_half;
      status_snap <= next_status_snap;
      protection_status_register <= status_now;
      power_down <= (next_state == FWP_POWER_DOWN);
    end
  end

endmodule : fwp_core

`default_nettype wire

// ### tb/fwp_core_asserts.sv
// Port assertions for the write-protect and status core.
// Assumes a bind onto fwp_core; only the sys_clk domain is watched.
`default_nettype none
module fwp_core_asserts
  import fwp_pkg::*;
#(
  parameter int POWER_UP_DELAY_CYCLES = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic write_protect_n,
  input wire logic op_done,
  input wire logic op_start,
  input wire logic [7:0] op_opcode,
  input wire logic [7:0] protection_status_register,
  input wire logic power_down
);
  logic [15:0] up_cnt;
  logic [15:0] next_up_cnt;
  wire busy = protection_status_register[0];
  // Cycles since reset release, saturating at the lockout length
  always_comb begin
    next_up_cnt = up_cnt;
    if (!rst_n) begin
      next_up_cnt = 16'h0000;
    end else if (up_cnt < 16'(POWER_UP_DELAY_CYCLES)) begin
      next_up_cnt = up_cnt + 16'h0001;
    end
  end
  always_ff @(posedge sys_clk) begin
    up_cnt <= next_up_cnt;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  sequence s_launch;
    op_start ##1 busy;
  endsequence
  sequence s_finish;
    ##[1:2] !busy ##[0:2] !protection_status_register[1];
  endsequence
  a_reset_quiet: assert property (!rst_n |=>
    protection_status_register == 8'h00 && !op_start && !power_down) else $error("reset not quiet");
  a_lockout_quiet: assert property (disable iff (!rst_n)
    up_cnt < 16'(POWER_UP_DELAY_CYCLES) |-> !op_start) else $error("start in lockout");
  a_start_busy: assert property (disable iff (!rst_n)
    op_start |-> s_launch) else $error("busy not set after start");
  a_start_latch: assert property (disable iff (!rst_n)
    op_start |-> protection_status_register[1]) else $error("start without latch");
  a_busy_no_start: assert property (disable iff (!rst_n)
    busy && $past(busy) |-> !op_start) else $error("start while busy");
  a_busy_clears: assert property (disable iff (!rst_n)
    op_done && busy |-> s_finish) else $error("busy or latch not cleared");
  a_reserved_zero: assert property (disable iff (!rst_n)
    !protection_status_register[6] && !protection_status_register[4]) else $error("reserved set");
  a_locked_no_write: assert property (disable iff (!rst_n)
    protection_status_register[7] && !write_protect_n && $past(write_protect_n, 5) == 1'b0
    |=> $stable(protection_status_register[5:2])) else $error("locked bits changed");
  a_pd_no_start: assert property (disable iff (!rst_n)
    power_down |-> !op_start) else $error("start in power-down");
endmodule : fwp_core_asserts
`default_nettype wire

// ### tb/fwp_spi_host.sv
// SPI host model sending whole-byte command frames, MSB first.
// Assumes mode 0: serial clock parked low outside frames.
`default_nettype none
module fwp_spi_host (
  output logic spi_clk,
  output logic cs_n,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Last byte shifted in from so_out; undriven output reads inverted
  task automatic frame(input logic [31:0] data, input int nbytes, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    cs_n = 1'b0;
    for (i = 8 * nbytes - 1; i >= 0; i--) begin
      si = data[i];
      #62.5 spi_clk = 1'b1;
      rd = {rd[6:0], so_oe_n ? ~so_out : so_out};
      #62.5 spi_clk = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    si = ~si;
    #500;
  endtask : frame
endmodule : fwp_spi_host
`default_nettype wire

// ### tb/fwp_core_tb.sv
// Self-checking bench for the write-protect and status core.
// Assumes the SPI host model and the bound checker.
`default_nettype none
module fwp_core_tb
  import fwp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PU_CYC = 40;
  logic sys_clk, rst_n, write_protect_n, op_done, spi_clk, cs_n, si, so_out, so_oe_n;
  logic op_start, op_upper_half, power_down, last_half;
  logic [7:0] op_opcode, psr, rd;
  int fails, comparisons, starts;
  fwp_core #(.POWER_UP_DELAY_CYCLES(PU_CYC)) fwp_core_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .spi_clk(spi_clk), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe_n(so_oe_n),
    .write_protect_n(write_protect_n), .op_done(op_done), .op_start(op_start),
    .op_opcode(op_opcode), .op_upper_half(op_upper_half), .protection_status_register(psr),
    .power_down(power_down));
  fwp_spi_host fwp_spi_host_inst (.spi_clk(spi_clk), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe_n(so_oe_n));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (op_start === 1'b1) begin
      starts++;
      last_half = op_upper_half;
    end
  end
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check
  task automatic cmd(input logic [31:0] data, input int nbytes);
    fwp_spi_host_inst.frame(data, nbytes, rd);
    repeat (8) @(negedge sys_clk);
  endtask : cmd
  task automatic wren;
    cmd({24'h0, OP_WRITE_ENABLE}, 1);
  endtask : wren
  task automatic done_op;
    @(negedge sys_clk) op_done = 1'b1;
    @(negedge sys_clk) op_done = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask : done_op
  task automatic print_verdict;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    #400000;
    fails++;
    print_verdict;
  end
  initial begin
    rst_n = 1'b0;
    write_protect_n = 1'b1;
    op_done = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    wren;
    check("latch in lockout", 8'h00, psr);
    repeat (PU_CYC) @(negedge sys_clk);
    check("status after power-up", 8'h00, psr);
    cmd({OP_PAGE_PROGRAM, 24'h000000}, 4);
    check("program without latch", 8'h00, 8'(starts));
    wren;
    check("latch set", 8'h02, psr);
    cmd({24'h0, OP_WRITE_DISABLE}, 1);
    check("latch cleared", 8'h00, psr);
    wren;
    cmd({16'h0, OP_WRITE_STATUS, 8'hFF}, 2);
    check("busy with bits", 8'hAF, psr);
    cmd({24'h0, OP_WRITE_DISABLE}, 1);
    cmd({16'h0, OP_READ_STATUS, 8'h00}, 2);
    check("read while busy", 8'hAF, rd & 8'hAF);
    done_op;
    check("after status write", 8'hAC, psr);
    write_protect_n = 1'b0;
    wren;
    cmd({16'h0, OP_WRITE_STATUS, 8'h00}, 2);
    check("locked status write", 8'hAE, psr);
    write_protect_n = 1'b1;
    cmd({16'h0, OP_WRITE_STATUS, 8'h04}, 2);
    done_op;
    check("unlocked write", 8'h04, psr);
    wren;
    cmd({OP_SECTOR_ERASE, 24'h010000}, 4);
    check("protected erase", 8'h02, 8'(starts));
    cmd({OP_PAGE_PROGRAM, 24'h000000}, 4);
    check("lower program", 8'h03, 8'(starts));
    done_op;
    check("latch after program", 8'h04, psr);
    write_protect_n = 1'b0;
    wren;
    cmd({16'h0, OP_WRITE_STATUS, 8'h24}, 2);
    done_op;
    check("write with pin low", 8'h24, psr);
    wren;
    cmd({OP_BLOCK_ERASE_64, 24'h010000}, 4);
    check("upper erase", 8'h01, {7'h0, last_half});
    check("erase opcode", OP_BLOCK_ERASE_64, op_opcode);
    done_op;
    cmd({24'h0, OP_POWER_DOWN}, 1);
    check("power-down", 8'h01, {7'h0, power_down});
    wren;
    check("ignored in power-down", 8'h24, psr);
    cmd({24'h0, OP_RELEASE_PD}, 1);
    wren;
    check("after release", 8'h26, psr);
    rst_n = 1'b0;
    wren;
    check("status in reset", 8'h00, psr);
    rst_n = 1'b1;
    repeat (PU_CYC + 8) @(negedge sys_clk);
    check("no command in reset", 8'h00, psr);
    print_verdict;
  end
endmodule : fwp_core_tb
bind fwp_core fwp_core_asserts #(.POWER_UP_DELAY_CYCLES(POWER_UP_DELAY_CYCLES))
  fwp_core_asserts_inst (.sys_clk(sys_clk), .rst_n(rst_n), .write_protect_n(write_protect_n),
  .op_done(op_done), .op_start(op_start), .op_opcode(op_opcode), .power_down(power_down),
  .protection_status_register(protection_status_register));
`default_nettype wire
